// ==== rtl/rpc_clock_pll_config.sv ====
// reference clock path configuration, divider, doubler and pll controls
`timescale 1ns/1ps
`include "rpc_regs.svh"
// Behaviour
// - writing one resets the reference input divider
// - divider codes divide by 1, 2, 4, 8
// - divider acts only when divider enable set
// - doubler runs only with both doubler bits
// - edge bit switches doubler circuit, needs enable
// - pll enable bit runs pll as system clock
// - pll multiplies reference by twice feedback N
// - N resets to 25, multiplication 50
// - manual bit picks manual or calibrated current
// - three-bit manual charge pump current code
// - lock detect enable switches lock detection, needs pll enable
// - lock reported after window count in-window ticks
// - window codes give 128, 256, 512, 1024 cycles
module rpc_clock_pll_config
  import rpc_pkg::*;
#(
  parameter int LOCK_CNT_W = 11
) (
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  input wire logic REF_CLK_IN,
  input wire logic PHASE_IN_WINDOW_IN,
  input wire logic [2:0] CAL_CP_CODE_IN,
  output logic PFD_REF_TICK_OUT,
  output logic PLL_ENABLE_OUT,
  output logic [8:0] PLL_MULT_OUT,
  output logic CP_MANUAL_OUT,
  output logic [2:0] CP_CURRENT_OUT,
  output logic LOCK_DETECT_EN_OUT,
  output logic LOCKED_OUT
);

  rpc_cfg_t cfg_r, cfg_nxt;
  logic div_rst_r, div_rst_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic cfg_hit;
  logic [31:0] cfg_word;

  // packing of the configuration into the register word
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`RPC_DIV_RST_BIT] = cfg_r.div_reset;
    cfg_word[`RPC_IN_DIV_HI:`RPC_IN_DIV_LO] = cfg_r.in_div;
    cfg_word[`RPC_DBL_EN_BIT] = cfg_r.dbl_en;
    cfg_word[`RPC_PLL_EN_BIT] = cfg_r.pll_en;
    cfg_word[`RPC_DIV_EN_BIT] = cfg_r.div_en;
    cfg_word[`RPC_DBL_EDGE_BIT] = cfg_r.dbl_edge;
    cfg_word[`RPC_FB_N_HI:`RPC_FB_N_LO] = cfg_r.fb_n;
    cfg_word[`RPC_CP_MAN_BIT] = cfg_r.cp_manual;
    cfg_word[`RPC_CP_HI:`RPC_CP_LO] = cfg_r.cp_code;
    cfg_word[`RPC_LOCK_EN_BIT] = cfg_r.lock_en;
    cfg_word[`RPC_LDW_HI:`RPC_LDW_LO] = cfg_r.lock_window_count;
  end

  assign cfg_hit = (REG_ADDR_IN == `RPC_CFG_ADDR);

  // register write, divider reset strobe and read data
  always_comb begin
    cfg_nxt = cfg_r;
    div_rst_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (REG_WR_IN && cfg_hit) begin
      cfg_nxt.div_reset = REG_WDATA_IN[`RPC_DIV_RST_BIT];
      cfg_nxt.in_div = REG_WDATA_IN[`RPC_IN_DIV_HI:`RPC_IN_DIV_LO];
      cfg_nxt.dbl_en = REG_WDATA_IN[`RPC_DBL_EN_BIT];
      cfg_nxt.pll_en = REG_WDATA_IN[`RPC_PLL_EN_BIT];
      cfg_nxt.div_en = REG_WDATA_IN[`RPC_DIV_EN_BIT];
      cfg_nxt.dbl_edge = REG_WDATA_IN[`RPC_DBL_EDGE_BIT];
      cfg_nxt.fb_n = REG_WDATA_IN[`RPC_FB_N_HI:`RPC_FB_N_LO];
      cfg_nxt.cp_manual = REG_WDATA_IN[`RPC_CP_MAN_BIT];
      cfg_nxt.cp_code = REG_WDATA_IN[`RPC_CP_HI:`RPC_CP_LO];
      cfg_nxt.lock_en = REG_WDATA_IN[`RPC_LOCK_EN_BIT];
      cfg_nxt.lock_window_count = REG_WDATA_IN[`RPC_LDW_HI:`RPC_LDW_LO];
      // each write of a one starts a fresh divider reset
      div_rst_nxt = REG_WDATA_IN[`RPC_DIV_RST_BIT];
    end
    if (REG_RD_IN) begin
      // unmapped addresses read as zero
      rdata_nxt = cfg_hit ? cfg_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      // fields set one by one; a raw word cast would misplace N by bit 7
      cfg_r <= '{fb_n: `RPC_FB_N_RESET, default: '0};
      div_rst_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      div_rst_r <= div_rst_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // reference edge detection; ref is sampled as a plain synchronous input
  logic ref_d_r, ref_d_nxt;
  logic ref_rise;
  logic ref_fall;
  logic dbl_on;
  logic edge_ev;

  assign ref_d_nxt = REF_CLK_IN;
  assign ref_rise = REF_CLK_IN & ~ref_d_r;
  assign ref_fall = ~REF_CLK_IN & ref_d_r;
  // doubler needs both its enable and its circuit bit
  assign dbl_on = cfg_r.dbl_en & cfg_r.dbl_edge;
  // doubling uses both reference edges, so duty cycle shapes the spacing
  assign edge_ev = ref_rise | (dbl_on & ref_fall);

  // input divider: power-of-two count of reference events
  logic [2:0] div_cnt_r, div_cnt_nxt;
  logic [2:0] div_mask;
  logic tick;
  logic tick_r, tick_nxt;

  always_comb begin
    case (cfg_r.in_div)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  // bypassed divider passes every event through
  assign tick = edge_ev &
                (~cfg_r.div_en | ((div_cnt_r & div_mask) == div_mask));

  always_comb begin
    div_cnt_nxt = div_cnt_r;
    if (div_rst_r) begin
      div_cnt_nxt = 3'h0;
    end else if (edge_ev && cfg_r.div_en) begin
      div_cnt_nxt = div_cnt_r + 3'h1;
    end
    tick_nxt = tick & ~div_rst_r;
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ref_d_r <= 1'b0;
      div_cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      ref_d_r <= ref_d_nxt;
      div_cnt_r <= div_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // static pll controls, registered onto the outputs
  logic pll_en_nxt;
  logic [8:0] mult_nxt;
  logic [2:0] cp_nxt;

  always_comb begin
    pll_en_nxt = cfg_r.pll_en;
    // fixed divide-by-two in feedback doubles N
    mult_nxt = {cfg_r.fb_n, 1'b0};
    // auto mode follows the calibration result
    cp_nxt = cfg_r.cp_manual ? cfg_r.cp_code : CAL_CP_CODE_IN;
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PLL_ENABLE_OUT <= 1'b0;
      PLL_MULT_OUT <= {`RPC_FB_N_RESET, 1'b0};
      CP_MANUAL_OUT <= 1'b0;
      CP_CURRENT_OUT <= 3'h0;
      LOCK_DETECT_EN_OUT <= 1'b0;
    end else begin
      PLL_ENABLE_OUT <= pll_en_nxt;
      PLL_MULT_OUT <= mult_nxt;
      CP_MANUAL_OUT <= cfg_r.cp_manual;
      CP_CURRENT_OUT <= cp_nxt;
      LOCK_DETECT_EN_OUT <= cfg_r.lock_en;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  assign PFD_REF_TICK_OUT = tick_r;

  // lock detection needs a running pll as well as its enable
  rpc_lock_detect #(
    .CNT_W(LOCK_CNT_W)
  ) u_lock (
    .clk_in(MCLK_IN),
    .rst_n_in(RESETN_IN),
    .enable_in(cfg_r.lock_en & cfg_r.pll_en),
    .in_window_in(PHASE_IN_WINDOW_IN),
    .tick_in(tick),
    .ldw_in(cfg_r.lock_window_count),
    .locked_out(LOCKED_OUT)
  );

endmodule

// ==== rtl/rpc_lock_detect.sv ====
// lock detector: counts in-window reference ticks up to the window count
`timescale 1ns/1ps
`include "rpc_regs.svh"
module rpc_lock_detect
  import rpc_pkg::*;
#(
  parameter int CNT_W = 11
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic in_window_in,
  input wire logic tick_in,
  input wire logic [1:0] ldw_in,
  output logic locked_out
);

  rpc_lock_st_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] target;

  // window count select
  always_comb begin
    case (ldw_in)
      2'h0: target = CNT_W'(`RPC_LDW_CNT0);
      2'h1: target = CNT_W'(`RPC_LDW_CNT1);
      2'h2: target = CNT_W'(`RPC_LDW_CNT2);
      default: target = CNT_W'(`RPC_LDW_CNT3);
    endcase
  end

  // next state: leaving the window restarts from zero and drops lock
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      RPC_LK_OFF: begin
        cnt_nxt = '0;
        if (enable_in) begin
          state_nxt = RPC_LK_COUNT;
        end
      end
      RPC_LK_COUNT: begin
        if (!in_window_in) begin
          cnt_nxt = '0;
        end else if (tick_in) begin
          if (cnt_r + CNT_W'(1) >= target) begin
            state_nxt = RPC_LK_LOCKED;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
      end
      RPC_LK_LOCKED: begin
        if (!in_window_in) begin
          state_nxt = RPC_LK_COUNT;
          cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = RPC_LK_OFF;
        cnt_nxt = '0;
      end
    endcase
    // disabling detection overrides everything
    if (!enable_in) begin
      state_nxt = RPC_LK_OFF;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= RPC_LK_OFF;
      cnt_r <= '0;
      locked_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      locked_out <= (state_nxt == RPC_LK_LOCKED);
    end
  end

endmodule

// ==== rtl/rpc_pkg.sv ====
// types for the reference clock and pll configuration block
package rpc_pkg;

  typedef struct packed {
    logic       div_reset;
    logic [1:0] in_div;
    logic       dbl_en;
    logic       pll_en;
    logic       div_en;
    logic       dbl_edge;
    logic [7:0] fb_n;
    logic       cp_manual;
    logic [2:0] cp_code;
    logic       lock_en;
    logic [1:0] lock_window_count;
  } rpc_cfg_t;

  typedef enum logic [1:0] {
    RPC_LK_OFF,
    RPC_LK_COUNT,
    RPC_LK_LOCKED
  } rpc_lock_st_t;

endpackage

// ==== rtl/rpc_regs.svh ====
// register offset, field positions, reset value and lock counts
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH

// register index on the programming port
`define RPC_CFG_ADDR 8'h02
`define RPC_CFG_RESET 32'h0000_1900

// field positions
`define RPC_DIV_RST_BIT 22
`define RPC_IN_DIV_HI 21
`define RPC_IN_DIV_LO 20
`define RPC_DBL_EN_BIT 19
`define RPC_PLL_EN_BIT 18
`define RPC_DIV_EN_BIT 17
`define RPC_DBL_EDGE_BIT 16
`define RPC_FB_N_HI 15
`define RPC_FB_N_LO 8
`define RPC_CP_MAN_BIT 6
`define RPC_CP_HI 5
`define RPC_CP_LO 3
`define RPC_LOCK_EN_BIT 2
`define RPC_LDW_HI 1
`define RPC_LDW_LO 0

// feedback divider reset value
`define RPC_FB_N_RESET 8'h19

// lock window counts in reference cycles
`define RPC_LDW_CNT0 11'h080
`define RPC_LDW_CNT1 11'h100
`define RPC_LDW_CNT2 11'h200
`define RPC_LDW_CNT3 11'h400

`endif

// ==== tb/rpc_clock_pll_config_monitor.sv ====
// port assertions for the reference clock and pll configuration block
`timescale 1ns/1ps
module rpc_clock_pll_config_monitor
  import rpc_pkg::*;
#(
  parameter int LOCK_CNT_W = 11
) (
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic REF_CLK_IN,
  input wire logic PHASE_IN_WINDOW_IN,
  input wire logic [2:0] CAL_CP_CODE_IN,
  input wire logic PFD_REF_TICK_OUT,
  input wire logic PLL_ENABLE_OUT,
  input wire logic [8:0] PLL_MULT_OUT,
  input wire logic CP_MANUAL_OUT,
  input wire logic [2:0] CP_CURRENT_OUT,
  input wire logic LOCK_DETECT_EN_OUT,
  input wire logic LOCKED_OUT
);
  logic wr_cfg;
  logic [10:0] win_cnt_r;
  logic [10:0] win_cnt_nxt;
  assign wr_cfg = REG_WR_IN && (REG_ADDR_IN == 8'h02);
  // in-window ticks at the port; a lower bound, so one tick of skew is fine
  always_comb begin
    win_cnt_nxt = win_cnt_r;
    if (!PHASE_IN_WINDOW_IN || !LOCK_DETECT_EN_OUT || !PLL_ENABLE_OUT)
      win_cnt_nxt = 11'h000;
    else if (PFD_REF_TICK_OUT && win_cnt_r != 11'h7FF)
      win_cnt_nxt = win_cnt_r + 11'h001;
  end
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) win_cnt_r <= 11'h000;
    else win_cnt_r <= win_cnt_nxt;
  end
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_mult_twice_n: assert property (wr_cfg |-> ##2
    PLL_MULT_OUT == {$past(REG_WDATA_IN[15:8], 2), 1'b0})
    else $error("multiplier is not twice N");
  a_pll_en_bit: assert property (wr_cfg |-> ##2
    PLL_ENABLE_OUT == $past(REG_WDATA_IN[18], 2))
    else $error("pll enable does not follow its bit");
  a_lock_en_bit: assert property (wr_cfg |-> ##2
    LOCK_DETECT_EN_OUT == $past(REG_WDATA_IN[2], 2))
    else $error("lock enable does not follow its bit");
  a_cp_manual_code: assert property (wr_cfg && REG_WDATA_IN[6] |-> ##2
    CP_MANUAL_OUT && CP_CURRENT_OUT == $past(REG_WDATA_IN[5:3], 2))
    else $error("manual pump code not applied");
  a_cp_auto_code: assert property ($past(RESETN_IN) && !CP_MANUAL_OUT
    |-> CP_CURRENT_OUT == $past(CAL_CP_CODE_IN))
    else $error("automatic pump code not applied");
  a_lock_drop: assert property (LOCKED_OUT && !PHASE_IN_WINDOW_IN
    |=> !LOCKED_OUT) else $error("lock held after leaving window");
  a_lock_needs_en: assert property (
    (!LOCK_DETECT_EN_OUT || !PLL_ENABLE_OUT) [*3] |-> !LOCKED_OUT)
    else $error("lock shown while detection is off");
  a_lock_min_ticks: assert property ($rose(LOCKED_OUT)
    |-> win_cnt_r >= 11'h07F) else $error("lock before window count");
  a_tick_one_cycle: assert property (PFD_REF_TICK_OUT
    |=> !PFD_REF_TICK_OUT) else $error("reference tick too long");
endmodule
bind rpc_clock_pll_config rpc_clock_pll_config_monitor
  #(.LOCK_CNT_W(LOCK_CNT_W)) rpc_clock_pll_config_monitor_inst (.*);

// ==== tb/rpc_ref_source.sv ====
// reference clock source model driving a fixed number of edges on request
`timescale 1ns/1ps
module rpc_ref_source #(
  parameter int HALF = 2
) (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [11:0] edges_in,
  output logic ref_out,
  output logic busy_out
);
  int left = 0;
  int ph = 0;
  initial ref_out = 1'b0;
  // clock stands still low between bursts; edges stay HALF cycles apart
  always @(posedge clk_in) begin
    if (start_in) begin
      left <= 2 * int'(edges_in);
      ph <= 0;
    end else if (left > 0) begin
      if (ph == HALF - 1) begin
        ref_out <= ~ref_out;
        left <= left - 1;
        ph <= 0;
      end else begin
        ph <= ph + 1;
      end
    end
  end
  assign busy_out = (left > 0);
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the reference clock and pll configuration block
`timescale 1ns/1ps
module tb;
  import rpc_pkg::*;
  logic MCLK_IN, RESETN_IN, REG_WR_IN, REG_RD_IN, PHASE_IN_WINDOW_IN;
  logic REF_CLK_IN, PFD_REF_TICK_OUT, PLL_ENABLE_OUT, CP_MANUAL_OUT;
  logic LOCK_DETECT_EN_OUT, LOCKED_OUT, start, busy;
  logic [7:0] REG_ADDR_IN;
  logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, rv;
  logic [2:0] CAL_CP_CODE_IN, CP_CURRENT_OUT;
  logic [8:0] PLL_MULT_OUT;
  logic [11:0] edges;
  int mismatches, compares, ticks, cycles;
  rpc_clock_pll_config rpc_clock_pll_config_inst (.*);
  rpc_ref_source rpc_ref_source_inst (.clk_in(MCLK_IN), .start_in(start),
    .edges_in(edges), .ref_out(REF_CLK_IN), .busy_out(busy));
  initial begin
    MCLK_IN = 1'b0;
    forever #12.5 MCLK_IN = ~MCLK_IN;
  end
  // tick tally and hang guard, ceiling well above the ~8.3k cycles needed
  always @(posedge MCLK_IN) begin
    cycles++;
    if (PFD_REF_TICK_OUT === 1'b1) ticks++;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // returns once the static outputs carry the new value
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    REG_ADDR_IN = a;
    REG_WDATA_IN = d;
    REG_WR_IN = 1'b1;
    @(negedge MCLK_IN);
    REG_WR_IN = 1'b0;
    @(negedge MCLK_IN);
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    REG_ADDR_IN = a;
    REG_RD_IN = 1'b1;
    @(negedge MCLK_IN);
    REG_RD_IN = 1'b0;
    @(negedge MCLK_IN);
    d = REG_RDATA_OUT;
  endtask
  task automatic run(int n);
    edges = n[11:0];
    start = 1'b1;
    @(negedge MCLK_IN);
    start = 1'b0;
    while (busy === 1'b1) @(negedge MCLK_IN);
    repeat (4) @(negedge MCLK_IN);
  endtask
  task automatic t_regs();
    check("mult_rst", {23'h0, PLL_MULT_OUT}, 32'h0000_0032);
    rd_reg(8'h02, rv);
    check("cfg_rst", rv, 32'h0000_1900);
    wr_reg(8'h02, 32'h8004_FFFF);
    check("pll_en", {31'h0, PLL_ENABLE_OUT}, 32'h0000_0001);
    check("mult", {23'h0, PLL_MULT_OUT}, 32'h0000_01FE);
    check("cp", {28'h0, CP_MANUAL_OUT, CP_CURRENT_OUT}, 32'hF);
    check("lk_en", {31'h0, LOCK_DETECT_EN_OUT}, 32'h1);
    wr_reg(8'h03, 32'h0000_0000);
    rd_reg(8'h02, rv);
    check("cfg_rd", rv, 32'h0004_FF7F);
    wr_reg(8'h02, 32'h0000_0A00);
    check("mult_min", {23'h0, PLL_MULT_OUT}, 32'h0000_0014);
    check("cp_auto", {28'h0, CP_MANUAL_OUT, CP_CURRENT_OUT}, 32'h5);
  endtask
  // divide codes, bypass and the doubler bit pairs, 16 rising edges each
  task automatic t_divider();
    logic [31:0] cfgs [8] = '{32'h0042_1900, 32'h0052_1900, 32'h0062_1900,
      32'h0072_1900, 32'h0030_1900, 32'h0009_1900, 32'h0008_1900,
      32'h0001_1900};
    int exp [8] = '{16, 8, 4, 2, 16, 32, 16, 16};
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h02, cfgs[i]);
      ticks = 0;
      run(16);
      check("ticks", ticks, exp[i]);
    end
  endtask
  task automatic t_lock();
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h02, 32'h0004_1904 | c);
      PHASE_IN_WINDOW_IN = 1'b1;
      @(negedge MCLK_IN);
      run((128 << c) - 1);
      check("early", {31'h0, LOCKED_OUT}, 32'h0);
      run(1);
      check("locked", {31'h0, LOCKED_OUT}, 32'h1);
      PHASE_IN_WINDOW_IN = 1'b0;
      repeat (2) @(negedge MCLK_IN);
      check("dropped", {31'h0, LOCKED_OUT}, 32'h0);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    RESETN_IN = 1'b0;
    REG_WR_IN = 1'b0;
    REG_RD_IN = 1'b0;
    REG_ADDR_IN = 8'h00;
    REG_WDATA_IN = 32'h0;
    PHASE_IN_WINDOW_IN = 1'b0;
    CAL_CP_CODE_IN = 3'h5; // stands in for calibration after enable
    start = 1'b0;
    edges = 12'h000;
    repeat (5) @(negedge MCLK_IN);
    RESETN_IN = 1'b1;
    @(negedge MCLK_IN);
    t_regs();
    t_divider();
    t_lock();
    end_of_test();
  end
endmodule
